// ===== ssxa_pkg.sv
// Package for the subtract/swap/xor datapath: opcodes, widths, flag slots
// Assumes an 8-bit accumulator core with a 128-entry file register space
package ssxa_pkg;
  localparam int unsigned DataW = 8;
  localparam int unsigned AddrW = 7;
  localparam int unsigned NibW = 4;
  // Flag bit positions in the flag vector
  localparam int unsigned FlagBorrowPos = 0;
  localparam int unsigned FlagNibblePos = 1;
  localparam int unsigned FlagNilPos = 2;
  localparam logic [2:0] FlagsReset = 3'h0;
  localparam logic [DataW-1:0] AccReset = 8'h00;
  // Operation select codes
  typedef enum logic [1:0] {
    SSXA_OP_SUB = 2'h0,
    SSXA_OP_SWAP = 2'h1,
    SSXA_OP_XORL = 2'h2,
    SSXA_OP_XORF = 2'h3
  } ssxa_op_t;
endpackage : ssxa_pkg

// ===== ssxa_calc.sv
// Combinational arithmetic unit for the subtract/swap/xor datapath
// Assumes operands are stable for the whole cycle of issue
`timescale 1ns/1ps
`default_nettype none
module ssxa_calc
  import ssxa_pkg::*;
(
  // Operation
  input wire ssxa_op_t opSel,
  input wire logic [DataW-1:0] accVal,
  input wire logic [DataW-1:0] fileVal,
  input wire logic [DataW-1:0] literalVal,
  // Result
  output logic [DataW-1:0] resultVal,
  output logic borrowOut,
  output logic nibbleBorrow
);
  logic [DataW:0] diffFull;
  logic [NibW:0] diffNib;

  always_comb begin
    // f minus accumulator, carry out set when no borrow
    diffFull = {1'b0, fileVal} + {1'b0, ~accVal} + 9'h001;
    diffNib = {1'b0, fileVal[NibW-1:0]} + {1'b0, ~accVal[NibW-1:0]} + 5'h01;
    borrowOut = diffFull[DataW];
    nibbleBorrow = diffNib[NibW];
    case (opSel)
      SSXA_OP_SUB: resultVal = diffFull[DataW-1:0];
      SSXA_OP_SWAP: resultVal = {fileVal[3:0], fileVal[7:4]};
      SSXA_OP_XORL: resultVal = accVal ^ literalVal;
      SSXA_OP_XORF: resultVal = accVal ^ fileVal;
      default: resultVal = '0;
    endcase
  end
endmodule : ssxa_calc
`default_nettype wire

// ===== ssxa_datapath.sv
// Execution datapath for subtract, nibble swap and exclusive-OR operations
// Assumes the decoder issues one operation per cycle with fileVal already read
//
// Summary of operation
// - Subtract computes file register minus accumulator, two's complement.
// - Swap exchanges nibbles of file register; no flags change.
// - Destination one writes result back to the addressed file register, except for literal XOR.
// - Destination zero writes result to accumulator, file register untouched.
// - Literal XOR into accumulator, updates only nil flag.
// - File XOR with accumulator, routed by destination, updates only nil flag.
`timescale 1ns/1ps
`default_nettype none
module ssxa_datapath
  import ssxa_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Issue from decoder
  input wire logic issueValid,
  input wire ssxa_op_t opSel,
  input wire logic destFile,
  input wire logic [AddrW-1:0] fileAddr,
  input wire logic [DataW-1:0] literalVal,
  input wire logic [DataW-1:0] fileVal,
  // File register write port
  output logic fileWrEn,
  output logic [AddrW-1:0] fileWrAddr,
  output logic [DataW-1:0] fileWrData,
  // Architectural state
  output logic [DataW-1:0] accOut,
  output logic borrow_out_flag,
  output logic nibble_borrow_flag,
  output logic result_nil_flag
);
  logic [DataW-1:0] accQ, accD;
  logic [2:0] flagsQ, flagsD;
  logic wrEnQ, wrEnD;
  logic [AddrW-1:0] wrAddrQ, wrAddrD;
  logic [DataW-1:0] wrDataQ, wrDataD;
  logic [DataW-1:0] resultVal;
  logic borrowOut, nibbleBorrow;
  logic toFile;

  // Zero test on a result byte
  function automatic logic isNil(logic [DataW-1:0] v);
    return v == '0;
  endfunction : isNil

  ssxa_calc calcUnit (
    .opSel(opSel),
    .accVal(accQ),
    .fileVal(fileVal),
    .literalVal(literalVal),
    .resultVal(resultVal),
    .borrowOut(borrowOut),
    .nibbleBorrow(nibbleBorrow)
  );

  always_comb begin
    accD = accQ;
    flagsD = flagsQ;
    wrEnD = 1'b0;
    wrAddrD = wrAddrQ;
    wrDataD = wrDataQ;
    toFile = destFile && (opSel != SSXA_OP_XORL);
    if (issueValid) begin
      if (toFile) begin
        wrEnD = 1'b1;
        wrAddrD = fileAddr;
        wrDataD = resultVal;
      end else begin
        accD = resultVal;
      end
      case (opSel)
        SSXA_OP_SUB: begin
          flagsD[FlagBorrowPos] = borrowOut;
          flagsD[FlagNibblePos] = nibbleBorrow;
          flagsD[FlagNilPos] = isNil(resultVal);
        end
        SSXA_OP_SWAP: flagsD = flagsQ;
        SSXA_OP_XORL: flagsD[FlagNilPos] = isNil(resultVal);
        SSXA_OP_XORF: flagsD[FlagNilPos] = isNil(resultVal);
        default: flagsD = flagsQ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      accQ <= AccReset;
      flagsQ <= FlagsReset;
      wrEnQ <= 1'b0;
      wrAddrQ <= '0;
      wrDataQ <= '0;
    end else begin
      accQ <= accD;
      flagsQ <= flagsD;
      wrEnQ <= wrEnD;
      wrAddrQ <= wrAddrD;
      wrDataQ <= wrDataD;
    end
  end

  assign fileWrEn = wrEnQ;
  assign fileWrAddr = wrAddrQ;
  assign fileWrData = wrDataQ;
  assign accOut = accQ;
  assign borrow_out_flag = flagsQ[FlagBorrowPos];
  assign nibble_borrow_flag = flagsQ[FlagNibblePos];
  assign result_nil_flag = flagsQ[FlagNilPos];

  // Checks
  sub_result_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel == SSXA_OP_SUB && !destFile
    |=> accOut == 8'($past(fileVal) - $past(accOut)))
    else $error("subtract result wrong");
  sub_borrow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel == SSXA_OP_SUB
    |=> borrow_out_flag == ($past(accOut) <= $past(fileVal)))
    else $error("borrow flag wrong");
  sub_nibble_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel == SSXA_OP_SUB
    |=> nibble_borrow_flag == ($past(accOut[3:0]) <= $past(fileVal[3:0])))
    else $error("nibble borrow flag wrong");
  swap_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel == SSXA_OP_SWAP
    |=> $stable({borrow_out_flag, nibble_borrow_flag, result_nil_flag}))
    else $error("swap changed flags");
  swap_data_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel == SSXA_OP_SWAP && destFile
    |=> fileWrData == {$past(fileVal[3:0]), $past(fileVal[7:4])})
    else $error("swap result wrong");
  file_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && destFile && opSel != SSXA_OP_XORL
    |=> fileWrEn && fileWrAddr == $past(fileAddr) && $stable(accOut))
    else $error("file writeback missing");
  acc_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && !destFile |=> !fileWrEn)
    else $error("file written for accumulator dest");
  xorl_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel == SSXA_OP_XORL
    |=> !fileWrEn && accOut == ($past(accOut) ^ $past(literalVal))
      && result_nil_flag == (accOut == 8'h00)
      && $stable({borrow_out_flag, nibble_borrow_flag}))
    else $error("literal xor wrong");
  xorf_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel == SSXA_OP_XORF
    |=> $stable({borrow_out_flag, nibble_borrow_flag})
      && result_nil_flag == (($past(accOut) ^ $past(fileVal)) == 8'h00))
    else $error("file xor flags wrong");

  sub_nil_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel == SSXA_OP_SUB
    |=> result_nil_flag == ($past(fileVal) == $past(accOut)))
    else $error("subtract nil flag wrong");

  sub_file_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel == SSXA_OP_SUB && destFile
    |=> fileWrData == 8'($past(fileVal) - $past(accOut)))
    else $error("subtract file result wrong");

  swap_acc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel == SSXA_OP_SWAP && !destFile
    |=> accOut == {$past(fileVal[3:0]), $past(fileVal[7:4])})
    else $error("swap accumulator result wrong");

  xorf_acc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel == SSXA_OP_XORF && !destFile
    |=> accOut == ($past(accOut) ^ $past(fileVal)))
    else $error("file xor accumulator result wrong");

  xorf_file_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel == SSXA_OP_XORF && destFile
    |=> fileWrData == ($past(accOut) ^ $past(fileVal)))
    else $error("file xor writeback result wrong");

  xorl_nil_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel == SSXA_OP_XORL
    |=> result_nil_flag == (($past(accOut) ^ $past(literalVal)) == 8'h00))
    else $error("literal xor nil flag wrong");

  xorl_port_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel == SSXA_OP_XORL
    |=> $stable({fileWrAddr, fileWrData}))
    else $error("literal xor touched file port");

  other_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel != SSXA_OP_SUB
    |=> $stable({borrow_out_flag, nibble_borrow_flag}))
    else $error("borrow flags changed outside subtract");

  acc_port_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && !destFile |=> $stable({fileWrAddr, fileWrData}))
    else $error("file port changed for accumulator dest");

  wr_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fileWrEn |-> $past(issueValid) && $past(destFile))
    else $error("file write without file dest issue");

  wr_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fileWrEn |-> fileWrAddr == $past(fileAddr))
    else $error("file write address wrong");

  wr_acc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fileWrEn |-> $stable(accOut))
    else $error("accumulator changed on file write");

  swap_nil_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issueValid && opSel == SSXA_OP_SWAP |=> $stable(result_nil_flag))
    else $error("swap changed nil flag");

  idle_state_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !issueValid |=> $stable(accOut) && !fileWrEn
      && $stable({borrow_out_flag, nibble_borrow_flag, result_nil_flag}))
    else $error("state changed without issue");

  idle_port_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !issueValid |=> $stable({fileWrAddr, fileWrData}))
    else $error("file port changed without issue");

  reset_clear_a: assert property (@(posedge ref_clk)
    !rst_n |=> accOut == AccReset && !fileWrEn
      && {result_nil_flag, nibble_borrow_flag, borrow_out_flag}
        == FlagsReset)
    else $error("reset did not clear state");
endmodule : ssxa_datapath
`default_nettype wire

// ===== ssxa_file_model.sv
// Partner model: data register file beside the datapath
// Assumes a write lands on the edge after the write pulse is seen
`timescale 1ns/1ps
`default_nettype none
module ssxa_file_model
  import ssxa_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Read and write ports
  input wire logic [AddrW-1:0] rdAddr,
  output logic [DataW-1:0] rdData,
  input wire logic wrEn,
  input wire logic [AddrW-1:0] wrAddr,
  input wire logic [DataW-1:0] wrData
);
  logic [DataW-1:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'h00;
  assign rdData = mem[rdAddr];
  always @(posedge ref_clk) if (wrEn) mem[wrAddr] <= wrData;
endmodule : ssxa_file_model
`default_nettype wire

// ===== tb_subtract_swap_xor_alu.sv
// Self-checking bench for the subtract/swap/xor datapath
// Assumes ssxa_pkg, ssxa_datapath and ssxa_file_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_subtract_swap_xor_alu
  import ssxa_pkg::*;
;
  logic ref_clk = 1'b0, rst_n = 1'b0, issueValid = 1'b0, destFile = 1'b0;
  ssxa_op_t opSel = SSXA_OP_SUB;
  logic [6:0] fileAddr = 7'h00, fileWrAddr;
  logic [7:0] literalVal = 8'h00, fileVal, fileWrData, accOut, acc = 8'h00;
  logic [7:0] mir [128];
  logic fileWrEn, borrow_out_flag, nibble_borrow_flag, result_nil_flag;
  logic fc = 1'b0, fn = 1'b0, fz = 1'b0, took = 1'b0;
  logic [26:0] note;
  logic [26:0] q [$];
  logic [31:0] rng = 32'h76ee;
  int fail_count = 0, compares = 0;
  ssxa_datapath DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .issueValid(issueValid), .opSel(opSel), .destFile(destFile),
    .fileAddr(fileAddr), .literalVal(literalVal), .fileVal(fileVal),
    .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr), .fileWrData(fileWrData),
    .accOut(accOut), .borrow_out_flag(borrow_out_flag),
    .nibble_borrow_flag(nibble_borrow_flag),
    .result_nil_flag(result_nil_flag));
  ssxa_file_model files (.ref_clk(ref_clk), .rdAddr(fileAddr),
    .rdData(fileVal), .wrEn(fileWrEn), .wrAddr(fileWrAddr),
    .wrData(fileWrData));
  initial forever #2.5 ref_clk = ~ref_clk;
  initial for (int i = 0; i < 128; i++) mir[i] = 8'h00;
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic issue(ssxa_op_t op, logic d, logic [6:0] a, logic [7:0] k);
    logic [7:0] f, r;
    logic w;
    f = mir[a];
    w = d && op != SSXA_OP_XORL;
    case (op)
      SSXA_OP_SUB: begin
        r = f - acc;
        fc = acc <= f;
        fn = acc[3:0] <= f[3:0];
      end
      SSXA_OP_SWAP: r = {f[3:0], f[7:4]};
      SSXA_OP_XORL: r = acc ^ k;
      default: r = acc ^ f;
    endcase
    if (op != SSXA_OP_SWAP) fz = r == 8'h00;
    if (w) mir[a] = r;
    else acc = r;
    q.push_back({acc, fz, fn, fc, w, a, r});
    issueValid = 1'b1;
    opSel = op;
    destFile = d;
    fileAddr = a;
    literalVal = k;
    @(posedge ref_clk);
    #1 issueValid = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : issue
  always @(posedge ref_clk) took <= issueValid & rst_n;
  always @(negedge ref_clk) if (took) begin
    note = q.pop_front();
    chk("accOut", note[26:19], accOut);
    chk("flags", note[18:16], {result_nil_flag, nibble_borrow_flag,
      borrow_out_flag});
    chk("fileWrEn", note[15], fileWrEn);
    if (note[15]) chk("fileWr", note[14:0], {fileWrAddr, fileWrData});
  end
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #20000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    @(posedge ref_clk);
    #1 chk("reset", 16'h0000, {accOut, fileWrEn, result_nil_flag,
      nibble_borrow_flag, borrow_out_flag});
    issue(SSXA_OP_XORL, 1'b1, 7'h05, 8'h05);
    issue(SSXA_OP_XORF, 1'b1, 7'h05, 8'h00);
    issue(SSXA_OP_XORL, 1'b0, 7'h00, 8'h06);
    issue(SSXA_OP_SUB, 1'b0, 7'h05, 8'h00);
    issue(SSXA_OP_SWAP, 1'b1, 7'h7f, 8'h00);
    $display("directed test done");
    for (int i = 0; i < 300; i++) begin
      rng = xs(rng);
      issue(ssxa_op_t'(rng[1:0]), rng[2], rng[9:3], rng[17:10]);
    end
    $display("random test done");
    print_verdict();
  end
endmodule : tb_subtract_swap_xor_alu
`default_nettype wire
